// ---- signal_loss_config_assertions.sv ----
/*
  Port checker for the signal-loss configuration register.
  Assumes it is bound to the top module, one clock domain.
*/
`timescale 1ns/1ps
module signal_loss_config_assertions
   import signal_loss_config_pkg::*;
#(
   parameter int LANES = DEFAULT_LANES
)
(
   input wire logic             clock,               // Config clock
   input wire logic             rstn,                // Reset, low
   input wire logic             cfg_write,           // Write strobe
   input wire logic [7:0]       cfg_wdata,           // Write data
   input wire logic [7:0]       cfg_rdata,           // Read-back
   input wire logic             cfg_changed,         // Change pulse
   input wire logic [1:0]       clock_level_sel,     // Level field
   input wire logic [LANES-1:0] detect_raw,          // Loss flags
   input wire logic [7:0]       assert_level_mv,     // Assert level
   input wire logic [7:0]       deassert_level_mv,   // De-assert level
   input wire logic             detector_power_down, // Detectors off
   input wire logic [LANES-1:0] signal_loss_alarm,   // Alarms
   input wire logic [LANES-1:0] squelch_active,      // Squelch
   input wire logic [LANES-1:0] data_out,            // Lane data
   input wire logic             clock_out_enable,    // Clock buffer on
   input wire logic [1:0]       clock_out_level      // Clock level
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Multi-cycle conditions except s_new, sync chain needs several edges
   sequence s_pd_quiet; (detector_power_down && !cfg_rdata[4]) [*2]; endsequence
   sequence s_lost; (detect_raw[0] && !detector_power_down && !cfg_rdata[4]) [*5]; endsequence
   sequence s_new; cfg_write && ((cfg_wdata & 8'hfd) != cfg_rdata); endsequence
   property p_reset; $rose(rstn) |-> cfg_rdata == 8'h20; endproperty
   property p_write; cfg_write |=> cfg_rdata == ($past(cfg_wdata) & 8'hfd); endproperty
   property p_levels; assert_level_mv == 8'h46 + 8'h0a * 8'(cfg_rdata[7:5])
      && deassert_level_mv == assert_level_mv + 8'h0a; endproperty
   property p_pd; detector_power_down == (cfg_rdata[7:5] == 3'h7); endproperty
   property p_pd_mask; s_pd_quiet |-> signal_loss_alarm == '0; endproperty
   property p_force; cfg_rdata[4] && $past(cfg_rdata[4]) |-> signal_loss_alarm == '1; endproperty
   property p_lost; s_lost |-> signal_loss_alarm[0]; endproperty
   property p_squelch; $stable(cfg_rdata[3]) |-> squelch_active == (signal_loss_alarm & {LANES{~cfg_rdata[3]}});
   endproperty
   property p_level; $stable(cfg_rdata[2]) |-> (squelch_active & (data_out ^ {LANES{~cfg_rdata[2]}})) == '0;
   endproperty
   property p_clk_en; clock_out_enable == cfg_rdata[0]; endproperty
   property p_clk_lvl; $stable(clock_level_sel) && $stable(cfg_rdata[0])
      |-> clock_out_level == (cfg_rdata[0] ? clock_level_sel : 2'h0); endproperty
   property p_changed; s_new |=> cfg_changed; endproperty
   a_reset: assert property (p_reset) else $error("reset value wrong");
   a_write: assert property (p_write) else $error("write not stored");
   a_levels: assert property (p_levels) else $error("levels wrong");
   a_pd: assert property (p_pd) else $error("power down wrong");
   a_pd_mask: assert property (p_pd_mask) else $error("alarm while powered down");
   a_force: assert property (p_force) else $error("forced alarm missing");
   a_lost: assert property (p_lost) else $error("alarm missing");
   a_squelch: assert property (p_squelch) else $error("squelch wrong");
   a_level: assert property (p_level) else $error("squelch level wrong");
   a_clk_en: assert property (p_clk_en) else $error("clock enable wrong");
   a_clk_lvl: assert property (p_clk_lvl) else $error("clock level wrong");
   a_changed: assert property (p_changed) else $error("change pulse missing");
endmodule : signal_loss_config_assertions

// ---- signal_loss_config_pkg.sv ----
/*
  Constants for the signal-loss and clock-output configuration register:
  field positions, reset value, threshold code meanings and level figures.
  Assumes a single configuration clock domain with an active-low reset.
*/
package signal_loss_config_pkg;

   // Register width and field positions
   localparam int          CFG_WIDTH        = 8;
   localparam int          THRESH_MSB       = 7;
   localparam int          THRESH_LSB       = 5;
   localparam int          THRESH_WIDTH     = 3;
   localparam int          FORCE_ALARM_BIT  = 4;
   localparam int          NO_SQUELCH_BIT   = 3;
   localparam int          SQUELCH_LOW_BIT  = 2;
   localparam int          RESERVED_BIT     = 1;
   localparam int          CLOCK_OUT_EN_BIT = 0;

   // Reset value: threshold 001b, every other bit clear
   localparam logic [7:0]  CFG_RESET        = 8'h20;
   // Bits that software can actually change
   localparam logic [7:0]  CFG_WRITE_MASK   = 8'hfd;

   // Threshold code with special meaning
   localparam logic [2:0]  THRESH_POWER_DOWN = 3'h7;

   // Level figures in mV, peak-to-peak differential
   localparam int          LEVEL_WIDTH       = 8;
   localparam logic [7:0]  ASSERT_BASE_MV    = 8'h46;
   localparam logic [7:0]  ASSERT_STEP_MV    = 8'h0a;
   localparam logic [7:0]  HYSTERESIS_MV     = 8'h0a;

   // Clock output level field width, held in another register
   localparam int          CLOCK_LEVEL_WIDTH = 2;

   // Default number of input channels
   localparam int          DEFAULT_LANES     = 2;

endpackage : signal_loss_config_pkg

// ---- signal_loss_config_register.sv ----
/*
  Signal-loss and recovered-clock-output configuration register.
  Holds the 8-bit register, decodes the threshold code into assert and
  de-assert levels for the analog detectors, drives the detector power
  down, and runs the per-lane alarm and squelch path.
  Assumes the configuration port logic delivers a one-cycle write strobe
  with data in this clock domain, and reads the register back level-wise.
  The clock output level field lives in a separate register and arrives
  here as a plain same-domain input.
*/
`timescale 1ns/1ps
module signal_loss_config_register
   import signal_loss_config_pkg::*;
#(
   parameter int LANES = DEFAULT_LANES
)
(
   input  wire logic                         clock,             // Configuration clock, 250 MHz
   input  wire logic                         rstn,              // Asynchronous reset, low
   input  wire logic                         cfg_write,         // Write strobe, one cycle
   input  wire logic [CFG_WIDTH-1:0]         cfg_wdata,         // Write data
   output logic      [CFG_WIDTH-1:0]         cfg_rdata,         // Register read-back
   output logic                              cfg_changed,       // Pulse after a value change
   input  wire logic [CLOCK_LEVEL_WIDTH-1:0] clock_level_sel,   // Level field, other register
   input  wire logic [LANES-1:0]             detect_raw,        // Analog detector loss flags
   input  wire logic [LANES-1:0]             data_raw,          // Lane data from the input
   output logic      [LEVEL_WIDTH-1:0]       assert_level_mv,   // Alarm assert level
   output logic      [LEVEL_WIDTH-1:0]       deassert_level_mv, // Alarm de-assert level
   output logic                              detector_power_down, // All detectors off
   output logic      [LANES-1:0]             signal_loss_alarm, // Alarm per lane
   output logic      [LANES-1:0]             squelch_active,    // Lane squelched
   output logic      [LANES-1:0]             data_out,          // Lane data after squelch
   output logic                              alarm_any,         // Any lane in alarm
   output logic                              clock_out_enable,  // Recovered clock buffer on
   output logic      [CLOCK_LEVEL_WIDTH-1:0] clock_out_level    // Level for clock buffer
);

   typedef struct packed {
      logic [CFG_WIDTH-1:0]         cfg;
      logic                         changed;
      logic [LEVEL_WIDTH-1:0]       assert_mv;
      logic [LEVEL_WIDTH-1:0]       deassert_mv;
      logic                         power_down;
      logic                         clock_en;
      logic [CLOCK_LEVEL_WIDTH-1:0] clock_level;
   } cfg_state_t;

   cfg_state_t state;
   cfg_state_t next_state;

   logic [LANES-1:0] lane_alarm;
   logic [LANES-1:0] lane_squelched;
   logic [LANES-1:0] lane_data;

   // Threshold code to assert level; de-assert sits one hysteresis step above
   function automatic logic [LEVEL_WIDTH-1:0] code_to_assert_mv
   (
      input logic [THRESH_WIDTH-1:0] code
   );
      logic [LEVEL_WIDTH-1:0] step_total;
      step_total = '0;
      for (int k = 0; k < (1 << THRESH_WIDTH); k++)
      begin
         if (k < int'(code))
         begin
            step_total = LEVEL_WIDTH'(step_total + ASSERT_STEP_MV);
         end
      end
      code_to_assert_mv = LEVEL_WIDTH'(ASSERT_BASE_MV + step_total);
   endfunction : code_to_assert_mv

   // Register fields and their derived controls
   function automatic logic [THRESH_WIDTH-1:0] thresh_of
   (
      input logic [CFG_WIDTH-1:0] value
   );
      thresh_of = value[THRESH_MSB:THRESH_LSB];
   endfunction : thresh_of

   // Next state: register write, then decoded controls
   always_comb
   begin
      next_state         = state;
      next_state.changed = 1'b0;
      if (cfg_write)
      begin
         // Reserved bit never stored, so it reads back zero
         next_state.cfg     = cfg_wdata & CFG_WRITE_MASK;
         next_state.changed = ((cfg_wdata & CFG_WRITE_MASK) != state.cfg);
      end
      // Levels follow the stored code; 111b also gets a figure, meaningless while powered down
      next_state.assert_mv   = code_to_assert_mv(thresh_of(next_state.cfg));
      next_state.deassert_mv = LEVEL_WIDTH'(code_to_assert_mv(thresh_of(next_state.cfg))
                                            + HYSTERESIS_MV);
      // One code shuts every lane's detector at once
      next_state.power_down  = (thresh_of(next_state.cfg) == THRESH_POWER_DOWN);
      next_state.clock_en    = next_state.cfg[CLOCK_OUT_EN_BIT];
      // Level only passed on while the buffer is enabled
      if (next_state.cfg[CLOCK_OUT_EN_BIT])
      begin
         next_state.clock_level = clock_level_sel;
      end
      else
      begin
         next_state.clock_level = '0;
      end
   end

   // State register; reset leaves threshold 001b with its two levels, the rest clear
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state.cfg         <= CFG_RESET;
         state.changed     <= 1'b0;
         state.assert_mv   <= ASSERT_BASE_MV + ASSERT_STEP_MV;
         state.deassert_mv <= ASSERT_BASE_MV + ASSERT_STEP_MV + HYSTERESIS_MV;
         state.power_down  <= 1'b0;
         state.clock_en    <= 1'b0;
         state.clock_level <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Alarm and squelch path, lanes synchronised inside
   signal_loss_lane_path #(
      .LANES (LANES)
   ) u_lane_path (
      .clock       (clock),
      .rstn        (rstn),
      .detect_raw  (detect_raw),
      .data_raw    (data_raw),
      .power_down  (state.power_down),
      .force_alarm (state.cfg[FORCE_ALARM_BIT]),
      .no_squelch  (state.cfg[NO_SQUELCH_BIT]),
      .squelch_low (state.cfg[SQUELCH_LOW_BIT]),
      .alarm       (lane_alarm),
      .squelched   (lane_squelched),
      .data_out    (lane_data)
   );

   // Outputs straight from flip-flops
   assign cfg_rdata           = state.cfg;
   assign cfg_changed         = state.changed;
   assign assert_level_mv     = state.assert_mv;
   assign deassert_level_mv   = state.deassert_mv;
   assign detector_power_down = state.power_down;
   assign clock_out_enable    = state.clock_en;
   assign clock_out_level     = state.clock_level;
   assign signal_loss_alarm   = lane_alarm;
   assign squelch_active      = lane_squelched;
   assign data_out            = lane_data;
   // Summary flag; a reduction of registered bits, no extra stage
   assign alarm_any           = |lane_alarm;

endmodule : signal_loss_config_register

// ---- signal_loss_lane_path.sv ----
/*
  Per-lane signal-loss alarm and squelch path.
  Assumes detector flags and lane data arrive asynchronously from the analog
  front end; configuration inputs come from the same clock domain.
*/
`timescale 1ns/1ps
module signal_loss_lane_path
   import signal_loss_config_pkg::*;
#(
   parameter int LANES = DEFAULT_LANES
)
(
   input  wire logic             clock,        // Configuration clock
   input  wire logic             rstn,         // Asynchronous reset, low
   input  wire logic [LANES-1:0] detect_raw,   // Detector says signal lost
   input  wire logic [LANES-1:0] data_raw,     // Incoming lane data
   input  wire logic             power_down,   // Detectors powered down
   input  wire logic             force_alarm,  // Hold alarm asserted
   input  wire logic             no_squelch,   // Never squelch on alarm
   input  wire logic             squelch_low,  // Squelch level low when set
   output logic      [LANES-1:0] alarm,        // signal_loss_alarm per lane
   output logic      [LANES-1:0] squelched,    // Lane is being squelched
   output logic      [LANES-1:0] data_out      // Lane data after squelch
);

   typedef struct packed {
      logic [LANES-1:0] detect_meta;
      logic [LANES-1:0] detect_sync;
      logic [LANES-1:0] data_meta;
      logic [LANES-1:0] data_sync;
      logic [LANES-1:0] alarm;
      logic [LANES-1:0] squelched;
      logic [LANES-1:0] data_out;
   } lane_state_t;

   lane_state_t state;
   lane_state_t next_state;

   // Next state: synchronise, then alarm and squelch decisions
   always_comb
   begin
      next_state             = state;
      next_state.detect_meta = detect_raw;
      next_state.detect_sync = state.detect_meta;
      next_state.data_meta   = data_raw;
      next_state.data_sync   = state.data_meta;
      for (int i = 0; i < LANES; i++)
      begin
         // A powered-down detector reports nothing; force still wins
         next_state.alarm[i] = force_alarm
                               | (~power_down & state.detect_sync[i]);
         next_state.squelched[i] = next_state.alarm[i] & ~no_squelch;
         if (next_state.squelched[i])
         begin
            next_state.data_out[i] = ~squelch_low;
         end
         else
         begin
            next_state.data_out[i] = state.data_sync[i];
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign alarm     = state.alarm;
   assign squelched = state.squelched;
   assign data_out  = state.data_out;

endmodule : signal_loss_lane_path

// ---- testbench.sv ----
/*
  Self-checking bench for the configuration register.
  Assumes the design package and the checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
   import signal_loss_config_pkg::*;
   localparam int LANES = 2;
   logic             clock = 0, rstn = 0, cfg_write = 0, cfg_changed, detector_power_down, alarm_any;
   logic             clock_out_enable;
   logic [7:0]       cfg_wdata = 8'h00, cfg_rdata, assert_level_mv, deassert_level_mv, shadow;
   logic [1:0]       clock_level_sel = 2'h0, clock_out_level;
   logic [LANES-1:0] detect_raw = '0, data_raw = '0, signal_loss_alarm, squelch_active, data_out;
   int               fails = 0, n_tests = 0, cycles = 0;
   signal_loss_config_register #(.LANES(LANES)) u_dut (.clock, .rstn, .cfg_write, .cfg_wdata, .cfg_rdata,
      .cfg_changed, .clock_level_sel, .detect_raw, .data_raw, .assert_level_mv, .deassert_level_mv,
      .detector_power_down, .signal_loss_alarm, .squelch_active, .data_out, .alarm_any, .clock_out_enable,
      .clock_out_level);
   // Clock, 4 ns period
   initial forever #2 clock = ~clock;
   // Hang guard, far above the roughly 500 cycles needed
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         close_out();
      end
   end
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task close_out;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   function logic [7:0] exp_assert(input logic [2:0] c);
      return 8'h46 + 8'h0a * 8'(c);
   endfunction : exp_assert
   // One write, then the decoded outputs one cycle later
   task write_cfg(input logic [7:0] d);
      logic [7:0] e;
      e = d & 8'hfd; // Reserved bit never stored
      @(negedge clock);
      cfg_write = 1;
      cfg_wdata = d;
      @(negedge clock);
      cfg_write = 0;
      check("changed", 8'(cfg_changed), 8'(e != shadow));
      shadow = e;
      check("rdata", cfg_rdata, e);
      check("assert", assert_level_mv, exp_assert(e[7:5]));
      check("deassert", deassert_level_mv, exp_assert(e[7:5]) + 8'h0a);
      check("power_down", 8'(detector_power_down), 8'(e[7:5] == 3'h7));
      check("clk_en", 8'(clock_out_enable), 8'(e[0]));
   endtask : write_cfg
   // Random lane inputs under one setting; waits out the sync chain
   task lanes(input logic [7:0] d);
      logic [LANES-1:0] al, sq;
      write_cfg(d);
      @(negedge clock);
      detect_raw = LANES'($urandom);
      data_raw = LANES'($urandom);
      clock_level_sel = 2'($urandom);
      repeat (6) @(negedge clock);
      al = d[4] ? '1 : (d[7:5] == 3'h7 ? '0 : detect_raw);
      sq = al & {LANES{~d[3]}};
      check("alarm", 8'(signal_loss_alarm), 8'(al));
      check("any", 8'(alarm_any), 8'(|al));
      check("squelch", 8'(squelch_active), 8'(sq));
      check("data", 8'(data_out), 8'((sq & {LANES{~d[2]}}) | (~sq & data_raw)));
      check("clk_lvl", 8'(clock_out_level), 8'(d[0] ? clock_level_sel : 2'h0));
   endtask : lanes
   // Main sequence
   initial
   begin
      void'($urandom(32'hbc113a00));
      shadow = 8'h20;
      repeat (5) @(negedge clock);
      check("rst_rdata", cfg_rdata, 8'h20);
      check("rst_assert", assert_level_mv, 8'h50);
      check("rst_deassert", deassert_level_mv, 8'h5a);
      check("rst_clk_en", 8'(clock_out_enable), 8'h00);
      rstn = 1;
      for (int i = 0; i < 8; i++)
         write_cfg({i[2:0], 5'($urandom) | 5'h02});
      for (int m = 0; m < 32; m++)
         lanes({m[4] ? 3'h7 : 3'h3, m[3:1], 1'b1, m[0]});
      for (int i = 0; i < 20; i++)
         lanes(8'($urandom));
      write_cfg(8'h41);
      write_cfg(8'h41);
      // Reset in mid-run returns the default
      @(negedge clock);
      rstn = 0;
      @(negedge clock);
      check("rst2_rdata", cfg_rdata, 8'h20);
      check("rst2_assert", assert_level_mv, 8'h50);
      check("rst2_clk_en", 8'(clock_out_enable), 8'h00);
      check("rst2_alarm", 8'(signal_loss_alarm), 8'h00);
      rstn = 1;
      shadow = 8'h20;
      write_cfg(8'h20);
      close_out();
   end
endmodule : testbench
bind signal_loss_config_register signal_loss_config_assertions #(.LANES(LANES)) u_chk (.clock, .rstn,
   .cfg_write, .cfg_wdata, .cfg_rdata, .cfg_changed, .clock_level_sel, .detect_raw, .assert_level_mv,
   .deassert_level_mv, .detector_power_down, .signal_loss_alarm, .squelch_active, .data_out,
   .clock_out_enable, .clock_out_level);
